// ---- design/timer_ch3_pkg.sv ----
// constants and carrier types for the channel 3 pin function block
// assumes a single 20 MHz core clock and a counter supplied by the timer core
package timer_ch3_pkg;
	// =====================================================================
	// register byte addresses
	localparam logic [7:0] CTRL_HIGH_ADDR = 8'h00;
	localparam logic [7:0] CTRL_LOW_ADDR = 8'h04;
	localparam logic [7:0] MODE_ADDR = 8'h08;
	localparam logic [7:0] PIN_STATUS_ADDR = 8'h0c;
	localparam logic [3:0] GREG_PAGE = 4'h1;
	// =====================================================================
	// field layout
	localparam int FIELD_W = 4;
	localparam int CODE_INPUT_BIT = 3;
	localparam int CODE_INIT_BIT = 2;
	localparam int MODE_BUF_C_BIT = 0;
	localparam int MODE_BUF_D_BIT = 1;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [15:0] GREG_RESET = 16'hffff;
	// =====================================================================
	// low two bits of a field
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	localparam logic [1:0] CAP_RISE = 2'h0;
	localparam logic [1:0] CAP_FALL = 2'h1;
	localparam logic [1:0] CAP_BOTH = 2'h2;
	// =====================================================================
	// bus slave phases, gray along idle-write-read
	typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_WRITE = 2'h1, PH_READ = 2'h3} bus_phase_t;

	// control handed to one pin unit
	typedef struct packed {
		logic [3:0] field;
		logic buffered;
		logic load_init;
	} pin_ctrl_t;

	// state of one pin unit
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic level;
		logic oe;
		logic capture;
		logic [15:0] cap_value;
	} pin_state_t;

	// state of the top block
	typedef struct packed {
		logic [7:0] ctrl_high;
		logic [7:0] ctrl_low;
		logic [1:0] mode;
		logic [3:0][15:0] greg;
		logic [3:0] load_init;
		bus_phase_t phase;
		logic [7:0] waddr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} top_state_t;
endpackage : timer_ch3_pkg

// ---- design/timer_ch3_pin_unit.sv ----
// compare and capture logic for one general register and its pin
// assumes counter and register value are on the core clock; pin is asynchronous
`timescale 1ns/1ps
module timer_ch3_pin_unit
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// control and values
	input wire timer_ch3_pkg::pin_ctrl_t ctrl_in,
	input wire logic [15:0] counter_in,
	input wire logic [15:0] greg_in,
	// pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_out,
	// capture result
	output logic capture_out,
	output logic [15:0] cap_value_out
);
	timer_ch3_pkg::pin_state_t s;
	timer_ch3_pkg::pin_state_t next_s;
	logic active;
	logic is_input;
	logic [1:0] code;
	logic rise;
	logic fall;
	logic match;

	// decode of the field and pin edges
	assign active = ~ctrl_in.buffered;
	assign is_input = ctrl_in.field[timer_ch3_pkg::CODE_INPUT_BIT];
	assign code = ctrl_in.field[1:0];
	assign rise = s.sync2 & ~s.prev;
	assign fall = ~s.sync2 & s.prev;
	assign match = counter_in == greg_in;

	// next state
	always_comb
	begin
		next_s = s;
		next_s.sync1 = pin_in;
		next_s.sync2 = s.sync1;
		next_s.prev = s.sync2;
		next_s.capture = 1'b0;
		next_s.oe = active & ~is_input & (code != timer_ch3_pkg::ACT_NONE);
		if (ctrl_in.load_init)
			next_s.level = ctrl_in.field[timer_ch3_pkg::CODE_INIT_BIT];
		else if (active & ~is_input & match)
		begin
			case (code)
				timer_ch3_pkg::ACT_LOW: next_s.level = 1'b0;
				timer_ch3_pkg::ACT_HIGH: next_s.level = 1'b1;
				timer_ch3_pkg::ACT_TOGGLE: next_s.level = ~s.level;
				default: next_s.level = s.level;
			endcase
		end
		if (active & is_input)
		begin
			case (code)
				timer_ch3_pkg::CAP_RISE: next_s.capture = rise;
				timer_ch3_pkg::CAP_FALL: next_s.capture = fall;
				timer_ch3_pkg::CAP_BOTH: next_s.capture = rise | fall;
				default: next_s.capture = 1'b0;
			endcase
		end
		if (next_s.capture)
			next_s.cap_value = counter_in;
	end

	// state register
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
			s <= '0;
		else
			s <= next_s;
	end

	assign pin_out = s.level;
	assign pin_oe_out = s.oe;
	assign capture_out = s.capture;
	assign cap_value_out = s.cap_value;

	// =====================================================================
	// checks
	toggle_match_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(active && !is_input && code == timer_ch3_pkg::ACT_TOGGLE && match && !ctrl_in.load_init)
		|=> pin_out == !$past(pin_out)) else $error("toggle on match missed");
	high_match_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(active && !is_input && code == timer_ch3_pkg::ACT_HIGH && match && !ctrl_in.load_init)
		|=> pin_out) else $error("high on match missed");
	low_match_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(active && !is_input && code == timer_ch3_pkg::ACT_LOW && match && !ctrl_in.load_init)
		|=> !pin_out) else $error("low on match missed");
	rise_capture_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(active && ctrl_in.field == 4'h8 && rise) |=> capture_out && cap_value_out == $past(counter_in))
		else $error("rising capture missed");
	fall_capture_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(active && ctrl_in.field[3] && code == timer_ch3_pkg::CAP_FALL) |=> capture_out == $past(fall))
		else $error("falling capture wrong");
	both_capture_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(active && ctrl_in.field[3] && code == timer_ch3_pkg::CAP_BOTH) |=> capture_out == $past(rise || fall))
		else $error("both-edge capture wrong");
	undefined_code_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(ctrl_in.field[3] && code == 2'h3) |=> !capture_out) else $error("undefined code captured");
	buffer_quiet_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		ctrl_in.buffered |=> !capture_out && !pin_oe_out) else $error("buffered register active");
endmodule : timer_ch3_pin_unit

// ---- design/timer_ch3_io_control.sv ----
// channel 3 pin function control with general registers, on an ahb-lite slave
// assumes counter_in comes from the timer core on core_clk_in; pins are asynchronous
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module timer_ch3_io_control
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// ahb-lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// timer core
	input wire logic [15:0] counter_in,
	// pins, bit 0 is pin a up to bit 3 pin d
	input wire logic [3:0] ch3_pin_in,
	output logic [3:0] ch3_pin_out,
	output logic [3:0] ch3_pin_oe_out,
	// capture events, one per general register
	output logic [3:0] capture_out
);
	// =====================================================================
	// state and wiring
	timer_ch3_pkg::top_state_t s;
	timer_ch3_pkg::top_state_t next_s;
	timer_ch3_pkg::pin_ctrl_t [3:0] pin_ctrl;
	logic [15:0] fields;
	logic [3:0] unit_level;
	logic [3:0] unit_oe;
	logic [3:0] unit_capture;
	logic [3:0][15:0] unit_cap_value;
	logic addr_valid;
	logic [7:0] addr;

	// fields in order a, b, c, d
	assign fields = {s.ctrl_low, s.ctrl_high};
	assign addr_valid = hsel_in & htrans_in[1] & hready_in;
	assign addr = haddr_in[7:0];

	// =====================================================================
	// one pin unit per general register
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_pin
			assign pin_ctrl[gi].field = fields[gi * timer_ch3_pkg::FIELD_W +: timer_ch3_pkg::FIELD_W];
			assign pin_ctrl[gi].load_init = s.load_init[gi];
			if (gi == 2)
			begin : g_buf_c
				assign pin_ctrl[gi].buffered = s.mode[timer_ch3_pkg::MODE_BUF_C_BIT];
			end
			else if (gi == 3)
			begin : g_buf_d
				assign pin_ctrl[gi].buffered = s.mode[timer_ch3_pkg::MODE_BUF_D_BIT];
			end
			else
			begin : g_no_buf
				assign pin_ctrl[gi].buffered = 1'b0;
			end
			timer_ch3_pin_unit u_pin
			(
				.core_clk_in(core_clk_in),
				.reset_in(reset_in),
				.ctrl_in(pin_ctrl[gi]),
				.counter_in(counter_in),
				.greg_in(s.greg[gi]),
				.pin_in(ch3_pin_in[gi]),
				.pin_out(unit_level[gi]),
				.pin_oe_out(unit_oe[gi]),
				.capture_out(unit_capture[gi]),
				.cap_value_out(unit_cap_value[gi])
			);
		end
	endgenerate

	// =====================================================================
	// read data mux for an address phase
	function automatic logic [31:0] read_word(input logic [7:0] a, input timer_ch3_pkg::top_state_t st,
		input logic [3:0] lvl, input logic [3:0] oe);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (a == timer_ch3_pkg::CTRL_HIGH_ADDR)
			w = {24'h00_0000, st.ctrl_high};
		else if (a == timer_ch3_pkg::CTRL_LOW_ADDR)
			w = {24'h00_0000, st.ctrl_low};
		else if (a == timer_ch3_pkg::MODE_ADDR)
			w = {30'h0000_0000, st.mode};
		else if (a == timer_ch3_pkg::PIN_STATUS_ADDR)
			w = {24'h00_0000, oe, lvl};
		else if (a[7:4] == timer_ch3_pkg::GREG_PAGE)
			w = {16'h0000, st.greg[a[3:2]]};
		return w;
	endfunction : read_word

	// =====================================================================
	// bus phases, register writes and captures
	always_comb
	begin
		next_s = s;
		next_s.load_init = 4'h0;
		next_s.hreadyout = 1'b1;
		next_s.hresp = 1'b0;
		// data phase of a write
		if (s.phase == timer_ch3_pkg::PH_WRITE)
		begin
			if (s.waddr == timer_ch3_pkg::CTRL_HIGH_ADDR)
			begin
				next_s.ctrl_high = hwdata_in[7:0];
				next_s.load_init[1:0] = 2'h3;
			end
			else if (s.waddr == timer_ch3_pkg::CTRL_LOW_ADDR)
			begin
				next_s.ctrl_low = hwdata_in[7:0];
				next_s.load_init[3:2] = 2'h3;
			end
			else if (s.waddr == timer_ch3_pkg::MODE_ADDR)
				next_s.mode = hwdata_in[1:0];
			else if (s.waddr[7:4] == timer_ch3_pkg::GREG_PAGE)
				next_s.greg[s.waddr[3:2]] = hwdata_in[15:0];
		end
		// captures win over a software write in the same cycle
		for (int i = 0; i < 4; i++)
		begin
			if (unit_capture[i])
				next_s.greg[i] = unit_cap_value[i];
		end
		// address phase
		next_s.phase = timer_ch3_pkg::PH_IDLE;
		if (addr_valid)
		begin
			if (hwrite_in)
			begin
				next_s.phase = timer_ch3_pkg::PH_WRITE;
				next_s.waddr = addr;
			end
			else
			begin
				next_s.phase = timer_ch3_pkg::PH_READ;
				next_s.hrdata = read_word(addr, s, unit_level, unit_oe);
			end
		end
	end

	// state register
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			s.ctrl_high <= timer_ch3_pkg::CTRL_RESET;
			s.ctrl_low <= timer_ch3_pkg::CTRL_RESET;
			s.mode <= timer_ch3_pkg::MODE_RESET;
			s.greg <= {4{timer_ch3_pkg::GREG_RESET}};
			s.load_init <= 4'h0;
			s.phase <= timer_ch3_pkg::PH_IDLE;
			s.waddr <= 8'h00;
			s.hrdata <= 32'h0000_0000;
			s.hreadyout <= 1'b1;
			s.hresp <= 1'b0;
		end
		else
			s <= next_s;
	end

	// outputs, all from flip-flops
	assign hrdata_out = s.hrdata;
	assign hreadyout_out = s.hreadyout;
	assign hresp_out = s.hresp;
	assign ch3_pin_out = unit_level;
	assign ch3_pin_oe_out = unit_oe;
	assign capture_out = unit_capture;

	// =====================================================================
	// checks
	fields_reset_a: assert property (@(posedge core_clk_in)
		$past(reset_in) |-> s.ctrl_high == 8'h00 && s.ctrl_low == 8'h00 && ch3_pin_oe_out == 4'h0)
		else $error("fields not zero after reset");
	high_write_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(addr_valid && hwrite_in && addr == timer_ch3_pkg::CTRL_HIGH_ADDR) ##1 !reset_in
		|=> s.ctrl_high == $past(hwdata_in[7:0])) else $error("high control write lost");
	low_write_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(addr_valid && hwrite_in && addr == timer_ch3_pkg::CTRL_LOW_ADDR) ##1 !reset_in
		|=> s.ctrl_low == $past(hwdata_in[7:0])) else $error("low control write lost");
	init_level_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		s.load_init[1] |=> ch3_pin_out[1] == $past(s.ctrl_high[6])) else $error("initial level wrong");
	capture_store_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		unit_capture[0] |=> s.greg[0] == $past(unit_cap_value[0])) else $error("capture not stored");
	disabled_out_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(s.ctrl_high[3:0] == 4'h4) [*2] |-> !ch3_pin_oe_out[0]) else $error("output enabled for x100");
	buffer_d_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		s.mode[timer_ch3_pkg::MODE_BUF_D_BIT] |=> !capture_out[3]) else $error("buffered d captured");
	buffer_c_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		s.mode[timer_ch3_pkg::MODE_BUF_C_BIT] |=> !ch3_pin_oe_out[2]) else $error("buffered c drives");
	read_back_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
		(addr_valid && !hwrite_in && addr == timer_ch3_pkg::MODE_ADDR) |=> hrdata_out == {30'h0, $past(s.mode)})
		else $error("mode read back wrong");
endmodule : timer_ch3_io_control

// ---- dv/timer_ch3_pin_model.sv ----
// far-side driver standing on the four channel 3 pins
// assumes the bench commands the level it drives while the device is off the pin
`timescale 1ns/1ps
module timer_ch3_pin_model
(
	// device side
	input wire logic [3:0] pin_in,
	input wire logic [3:0] oe_in,
	// bench command
	input wire logic [3:0] drive_in,
	// resolved pin level
	output logic [3:0] level_out
);
	// device wins where it drives, the far driver elsewhere
	assign level_out = (oe_in & pin_in) | (~oe_in & drive_in);
endmodule : timer_ch3_pin_model

// ---- dv/timer_ch3_io_control_test.sv ----
// self-checking bench for the channel 3 pin function block
// assumes the far-side pin model and one 20 MHz clock
`timescale 1ns/1ps
module timer_ch3_io_control_test;
	// =====================================================================
	// stimulus, outputs and model state
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [15:0] cnt = 16'h0;
	logic [3:0] drv = 4'h0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic [3:0] lvl;
	logic [3:0] pout;
	logic [3:0] poe;
	logic [3:0] cap;
	logic [3:0] fld [4];
	logic [15:0] eg [4];
	logic [3:0] eoe = 4'h0;
	logic [3:0] elv = 4'h0;
	logic [1:0] emode = 2'h0;
	logic [31:0] q;
	int cap_cnt [4] = '{0, 0, 0, 0};
	int error_cnt = 0;
	int total_checks = 0;
	int seed = 57497;

	// 50 ns clock
	always #25 clk = ~clk;

	timer_ch3_io_control timer_ch3_io_control_inst (.core_clk_in(clk), .reset_in(rst), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.counter_in(cnt), .ch3_pin_in(lvl), .ch3_pin_out(pout), .ch3_pin_oe_out(poe), .capture_out(cap));
	timer_ch3_pin_model timer_ch3_pin_model_inst (.pin_in(pout), .oe_in(poe), .drive_in(drv),
		.level_out(lvl));

	// capture pulse counters
	always @(posedge clk)
		for (int k = 0; k < 4; k++)
			cap_cnt[k] <= cap_cnt[k] + int'(cap[k]);

	// =====================================================================
	// tasks
	function automatic logic bufd(input int k);
		return (k == 2 && emode[0]) || (k == 3 && emode[1]);
	endfunction : bufd

	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// one single transfer, entered just after an edge
	task bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr_en;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
		check({31'h0, hresp}, 32'h0);
	endtask : bus

	// write with model update
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, q);
		if (a == timer_ch3_pkg::MODE_ADDR)
			emode = d[1:0];
		if (a[7:4] == timer_ch3_pkg::GREG_PAGE)
			eg[a[3:2]] = d[15:0];
		for (int k = 0; k < 4; k++)
		begin
			if (a == {5'h0, k[1], 2'h0})
			begin
				fld[k] = d[4 * k[0] +: 4];
				elv[k] = d[4 * k[0] + 2];
			end
			eoe[k] = !fld[k][3] && fld[k][1:0] != 2'h0 && !bufd(k);
		end
	endtask : wr

	task set_field(input int u, input logic [3:0] c);
		wr(u < 2 ? timer_ch3_pkg::CTRL_HIGH_ADDR : timer_ch3_pkg::CTRL_LOW_ADDR, {24'h0, 8'(c) << (4 * (u % 2))});
		repeat (3) @(posedge clk);
	endtask : set_field

	task pins();
		check({28'h0, poe}, {28'h0, eoe});
		check({28'h0, pout & poe}, {28'h0, elv & eoe});
		bus(1'b0, timer_ch3_pkg::PIN_STATUS_ADDR, 32'h0, q);
		check(q, {24'h0, eoe, elv});
	endtask : pins

	// counter equal to v for exactly one cycle
	task hit(input logic [15:0] v);
		cnt <= v;
		@(posedge clk);
		cnt <= 16'h0;
		for (int k = 0; k < 4; k++)
			if (eg[k] == v && !fld[k][3] && !bufd(k))
				elv[k] = fld[k][1] ? (fld[k][0] ? ~elv[k] : 1'b1) : (fld[k][0] ? 1'b0 : elv[k]);
		repeat (3) @(posedge clk);
	endtask : hit

	// one pin edge with the counter held at a fresh value
	task edge_cap(input int u, input logic up);
		logic [15:0] w;
		logic want;
		int b;
		w = 16'($random(seed)) | 16'h1;
		want = fld[u][3] && !bufd(u) && (fld[u][1:0] == 2'h2 || fld[u][1:0] == {1'b0, ~up});
		cnt <= w;
		@(posedge clk);
		b = cap_cnt[u];
		drv[u] <= up;
		repeat (8) @(posedge clk);
		check(32'(cap_cnt[u] - b), {31'h0, want});
		if (want)
			eg[u] = w;
		cnt <= 16'h0;
		bus(1'b0, {timer_ch3_pkg::GREG_PAGE, 2'(u), 2'h0}, 32'h0, q);
		check(q, {16'h0, eg[u]});
	endtask : edge_cap

	task end_of_test();
		$display("checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	// =====================================================================
	// main sequence
	initial
	begin
		logic [15:0] v;
		fork
			begin
				repeat (5000) @(posedge clk);
				error_cnt++;
				end_of_test();
			end
		join_none
		for (int k = 0; k < 4; k++)
		begin
			fld[k] = 4'h0;
			eg[k] = timer_ch3_pkg::GREG_RESET;
		end
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// reset values, then an unmapped place
		for (int a = 0; a < 8; a++)
		begin
			bus(1'b0, 8'(4 * a), 32'h0, q);
			check(q, a > 3 ? {16'h0, timer_ch3_pkg::GREG_RESET} : 32'h0);
		end
		wr(8'h40, $random(seed));
		bus(1'b0, 8'h40, 32'h0, q);
		check(q, 32'h0);
		wr(timer_ch3_pkg::CTRL_HIGH_ADDR, 32'hffff_ffa0);
		bus(1'b0, timer_ch3_pkg::CTRL_HIGH_ADDR, 32'h0, q);
		check(q, 32'h0000_00a0);
		// every compare code on every pin
		for (int u = 0; u < 4; u++)
			for (int c = 0; c < 8; c++)
			begin
				v = 16'($random(seed)) | 16'h1;
				wr({timer_ch3_pkg::GREG_PAGE, 2'(u), 2'h0}, {16'h0, v});
				set_field(u, 4'(c));
				pins();
				hit(v);
				pins();
			end
		// every capture code on every pin
		for (int u = 0; u < 4; u++)
		begin
			set_field(u, 4'h0);
			for (int c = 8; c < 12; c++)
			begin
				set_field(u, 4'(c));
				edge_cap(u, 1'b1);
				edge_cap(u, 1'b0);
			end
		end
		// buffered c and d
		wr(timer_ch3_pkg::MODE_ADDR, 32'h3);
		bus(1'b0, timer_ch3_pkg::MODE_ADDR, 32'h0, q);
		check(q, 32'h3);
		set_field(2, 4'h8);
		edge_cap(2, 1'b1);
		set_field(3, 4'h7);
		pins();
		hit(eg[3]);
		pins();
		wr(timer_ch3_pkg::MODE_ADDR, 32'h0);
		// mode lands at the data edge, the output enable follows one edge later
		repeat (3) @(posedge clk);
		pins();
		hit(eg[3]);
		pins();
		end_of_test();
	end
endmodule : timer_ch3_io_control_test
